/* File: dv/srio_link_model.sv */
`timescale 1ns/10ps
// ------
// link side: random stalls, accepts packets oldest first
// ------
module srio_link_model (
  input  wire logic       i_mclk,
  input  wire logic       i_hold_acc,
  input  wire logic       i_stall_sym,
  input  wire logic       i_pkt_valid,
  input  wire logic       i_pkt_sop,
  input  wire logic       i_pkt_eop,
  input  wire logic       i_pkt_stomp,
  input  wire logic [4:0] i_pkt_id,
  output logic            o_pkt_ready,
  output logic            o_symq_ready,
  output logic            o_acc_valid,
  output logic [4:0]      o_acc_ackid
);
  logic [4:0] done_q[$];
  logic [4:0] cur;

  initial {o_pkt_ready, o_symq_ready, o_acc_valid, o_acc_ackid} = 8'h00;
  // sample on the edge, answer just after it; stomped packets never accepted
  always @(posedge i_mclk) begin
    if (i_pkt_valid && o_pkt_ready && i_pkt_sop)
      cur = i_pkt_id;
    if (i_pkt_valid && o_pkt_ready && i_pkt_eop && !i_pkt_stomp)
      done_q.push_back(cur);
    #1;
    o_pkt_ready = ($urandom % 4 != 0);
    o_symq_ready = !i_stall_sym && ($urandom % 2);
    if (o_acc_valid) begin
      o_acc_valid = 1'b0;
      o_acc_ackid = ~o_acc_ackid;
    end else if (done_q.size() && !i_hold_acc && $urandom % 3 == 0) begin
      o_acc_ackid = done_q.pop_front();
      o_acc_valid = 1'b1;
    end
  end
endmodule

/* File: dv/srio_tx_front_assertions.sv */
`timescale 1ns/10ps
// ------
// port checker for the transmit front end
// ------
module srio_tx_front_assertions (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_tx_valid,
  input wire logic        i_tx_discard,
  input wire logic        o_tx_ready,
  input wire logic [4:0]  o_tx_next_ackid,
  input wire logic        o_tx_rel_valid,
  input wire logic [4:0]  o_tx_rel_ackid,
  input wire logic        i_acc_valid,
  input wire logic [4:0]  i_acc_ackid,
  input wire logic        i_retry,
  input wire logic        o_pkt_valid,
  input wire logic [31:0] o_pkt_data,
  input wire logic        o_pkt_sop,
  input wire logic        o_pkt_eop,
  input wire logic        o_pkt_stomp,
  input wire logic        i_pkt_ready,
  input wire logic        o_symq_valid,
  input wire logic [63:0] o_symq_pair,
  input wire logic        i_symq_ready
);
  // independent symbol crc, msb first from all ones
  function automatic logic [4:0] crc5(input logic [18:0] f);
    logic [4:0] c;
    c = 5'h1f;
    for (int i = 18; i >= 0; i--)
      c = {c[3:0], 1'b0} ^ ((c[4] ^ f[i]) ? 5'h15 : 5'h00);
    return c;
  endfunction

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // a release answers the accept of the cycle before
  chk_rel_after_acc: assert property (o_tx_rel_valid |->
    $past(i_acc_valid) && o_tx_rel_ackid == $past(i_acc_ackid))
    else $error("release without matching accept");
  // ack id moves only forward by one unless rewound
  chk_ackid_step: assert property (
    $changed(o_tx_next_ackid) && !$past(i_retry) |->
    o_tx_next_ackid == $past(o_tx_next_ackid) + 5'h01)
    else $error("ack id jumped");
  chk_ready_drop: assert property (
    o_tx_ready && i_tx_valid && !i_tx_discard |=> !o_tx_ready)
    else $error("ready stayed high after a take");
  chk_pkt_hold: assert property (o_pkt_valid && !i_pkt_ready |=>
    o_pkt_valid && $stable({o_pkt_data, o_pkt_sop, o_pkt_eop, o_pkt_stomp}))
    else $error("packet head changed while stalled");
  chk_symq_hold: assert property (o_symq_valid && !i_symq_ready |=>
    o_symq_valid && $stable(o_symq_pair))
    else $error("symbol pair changed while stalled");
  chk_sym_delim: assert property (o_symq_valid |->
    o_symq_pair[63:56] == 8'h1c && o_symq_pair[31:24] == 8'h1c)
    else $error("symbol delimiter wrong");
  chk_sym_crc5: assert property (o_symq_valid |->
    o_symq_pair[36:32] == crc5(o_symq_pair[55:37]) &&
    o_symq_pair[4:0] == crc5(o_symq_pair[23:5]))
    else $error("symbol crc wrong");
  chk_stomp_empty: assert property (o_pkt_valid && o_pkt_stomp |->
    o_pkt_eop && !o_pkt_sop && o_pkt_data == 32'h0000_0000)
    else $error("stomp entry malformed");

  cover property (o_pkt_valid && o_pkt_stomp && i_pkt_ready);
  cover property (o_tx_rel_valid);
  cover property (o_symq_valid && o_symq_pair[23:21] == 3'h4);
endmodule

/* File: dv/test_srio_tx_front.sv */
`timescale 1ns/10ps
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_srio_tx_front;
  logic        i_mclk = 0, i_rst = 1, i_tx_valid = 0, i_tx_sop = 0;
  logic        i_tx_eop = 0, i_tx_half = 0, i_tx_discard = 0, retry = 0;
  logic        i_sym_valid = 0, hold_acc = 0, stall_sym = 0, pend_v = 0;
  logic [31:0] i_tx_data = 0, pend;
  logic [18:0] sym_f = 0;
  logic [4:0]  ack_exp = 0, rel_exp = 0;
  logic [34:0] exp_w;
  logic [63:0] exp_s;
  logic [35:0] exp_q[$];
  logic [63:0] sym_q[$];
  int          fail_count = 0, compares = 0;
  wire         o_tx_ready, o_tx_rel_valid, o_pkt_valid, o_pkt_sop, o_pkt_eop;
  wire         o_pkt_stomp, o_sym_ready, o_symq_valid, i_pkt_ready;
  wire         i_symq_ready, i_acc_valid;
  wire [4:0]   o_tx_next_ackid, o_tx_rel_ackid, i_acc_ackid;
  wire [31:0]  o_pkt_data;
  wire [63:0]  o_symq_pair;

  always #2.5 i_mclk = ~i_mclk;

  srio_tx_front dut_u (.i_mclk, .i_rst, .i_tx_valid, .i_tx_sop, .i_tx_eop,
    .i_tx_half, .i_tx_data, .i_tx_discard, .o_tx_ready, .o_tx_next_ackid,
    .o_tx_rel_valid, .o_tx_rel_ackid, .i_acc_valid, .i_acc_ackid,
    .i_retry(retry), .o_pkt_valid, .o_pkt_data, .o_pkt_sop, .o_pkt_eop,
    .o_pkt_stomp, .i_pkt_ready, .i_sym_valid, .i_sym_stype0(sym_f[18:16]),
    .i_sym_par0(sym_f[15:11]), .i_sym_par1(sym_f[10:6]),
    .i_sym_stype1(sym_f[5:3]), .i_sym_cmd(sym_f[2:0]), .o_sym_ready,
    .o_symq_valid, .o_symq_pair, .i_symq_ready);

  srio_link_model link_u (.i_mclk, .i_hold_acc(hold_acc),
    .i_stall_sym(stall_sym), .i_pkt_valid(o_pkt_valid),
    .i_pkt_sop(o_pkt_sop), .i_pkt_eop(o_pkt_eop), .i_pkt_stomp(o_pkt_stomp),
    .i_pkt_id(o_pkt_data[31:27]), .o_pkt_ready(i_pkt_ready),
    .o_symq_ready(i_symq_ready), .o_acc_valid(i_acc_valid),
    .o_acc_ackid(i_acc_ackid));

  function automatic logic [15:0] crc16(input logic [15:0] c,
                                        input logic [15:0] h);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ h[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  function automatic logic [31:0] sym32(input logic [18:0] f);
    logic [4:0] c;
    c = 5'h1f;
    for (int i = 18; i >= 0; i--)
      c = {c[3:0], 1'b0} ^ ((c[4] ^ f[i]) ? 5'h15 : 5'h00);
    return {8'h1c, f, c};
  endfunction

  // ------
  // monitors: packet stream, releases, symbol pairing
  // ------
  always @(posedge i_mclk) begin
    if (o_pkt_valid === 1'b1 && i_pkt_ready) begin
      // prefix words of a discarded packet may or may not have gone out
      while (exp_q.size() > 1 && exp_q[0][35] && exp_q[0][34:0] !==
             {o_pkt_sop, o_pkt_eop, o_pkt_stomp, o_pkt_data})
        void'(exp_q.pop_front());
      exp_w = exp_q.size() ? exp_q.pop_front() : 36'h0_0000_0000;
      `CHECK({o_pkt_sop, o_pkt_eop, o_pkt_stomp, o_pkt_data}, exp_w)
    end
    if (o_tx_rel_valid === 1'b1) begin
      `CHECK(o_tx_rel_ackid, rel_exp)
      rel_exp++;
    end
    if (i_sym_valid && o_sym_ready === 1'b1) begin
      if (pend_v)
        sym_q.push_back({pend, sym32(sym_f)});
      else
        pend = sym32(sym_f);
      pend_v = !pend_v;
    end else if (pend_v) begin
      sym_q.push_back({pend, sym32({3'h4, 5'h00, 5'h1f, 3'h7, 3'h0})});
      pend_v = 0;
    end
    if (o_symq_valid === 1'b1 && i_symq_ready) begin
      exp_s = sym_q.size() ? sym_q.pop_front() : 64'h0000_0000_0000_0000;
      `CHECK(o_symq_pair, exp_s)
    end
  end

  task summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task bail();
    fail_count++;
    $display("Error t=%0t wait limit got %h exp %h", $time, 1'b0, 1'b1);
    summarize();
  endtask
  task idle(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  // request stays put until the edge that sees ready high
  task wait_rdy(input bit s);
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while ((s ? o_sym_ready : o_tx_ready) !== 1'b1 && n < 500);
    if (n >= 500)
      bail();
    #1;
  endtask
  task drain(input string name);
    int n;
    n = 0;
    while ((exp_q.size() || sym_q.size() || rel_exp != ack_exp) && n < 4000)
    begin
      idle(1);
      n++;
    end
    if (n >= 4000)
      bail();
    idle(3);
    `CHECK(o_tx_next_ackid, ack_exp)
    $display("test %s done", name);
  endtask

  // cut >= 0 abandons the packet before word number cut
  task automatic send_pkt(input int n, input int cut);
    logic [15:0] h[$], o[$];
    logic [15:0] c;
    int w;
    for (w = 0; w < n; w++)
      h.push_back(16'($urandom));
    c = crc16(16'hffff, {6'h00, h[0][9:0]});
    o.push_back({ack_exp, 1'b0, h[0][9:0]});
    for (w = 1; w < n; w++) begin
      if (w == 40) begin
        o.push_back(c);
        c = crc16(c, c);
      end
      o.push_back(h[w]);
      c = crc16(c, h[w]);
    end
    o.push_back(c);
    if (o.size() % 2)
      o.push_back(16'h0000);
    for (w = 0; w < o.size(); w += 2)
      if (cut < 0 || w / 2 < cut)
        exp_q.push_back({cut >= 0, w == 0, w + 2 >= o.size(), 1'b0,
                         o[w], o[w+1]});
    for (w = 0; w < (n + 1) / 2 && w != cut; w++) begin
      i_tx_valid = 1;
      i_tx_sop = (w == 0);
      i_tx_eop = (2 * w + 2 >= n);
      i_tx_half = (2 * w + 1 == n);
      i_tx_data = {h[2*w], (2 * w + 1 < n) ? h[2*w+1] : 16'h0000};
      wait_rdy(0);
    end
    i_tx_valid = 0;
    i_tx_data = ~i_tx_data;
    if (cut >= 0) begin
      exp_q.push_back({1'b0, 3'b011, 32'h0000_0000});
      i_tx_discard = 1;
      idle(1);
      i_tx_discard = 0;
    end else begin
      ack_exp++;
      idle(1); // an edge passes before the next call raises valid
    end
  endtask

  int lens[6] = '{2, 3, 40, 41, 42, 61};
  bit took;
  initial begin
    void'($urandom(32'h78d6));
    idle(5);
    i_rst = 0;
    idle(2);
    `CHECK(o_tx_ready, 1'b1)
    $display("test reset done");
    for (int k = 0; k < 26; k++) begin
      send_pkt(k < 6 ? lens[k] : 1 + $urandom % 64, -1);
      idle($urandom % 3);
    end
    drain("packets");
    // rewind with nothing outstanding must leave the id in place
    retry = 1;
    idle(1);
    retry = 0;
    idle(1);
    `CHECK(o_tx_next_ackid, ack_exp)
    send_pkt(10, 3);
    send_pkt(4, -1);
    drain("discard");
    hold_acc = 1;
    repeat (32) send_pkt(2, -1);
    idle(40);
    `CHECK(o_tx_ready, 1'b0)
    hold_acc = 0;
    send_pkt(2, -1);
    drain("ackq_full");
    for (int k = 0; k < 40; k++) begin
      i_sym_valid = 1;
      sym_f = 19'($urandom);
      wait_rdy(1);
      if ($urandom % 2) begin
        i_sym_valid = 0;
        idle(2);
      end
    end
    idle(1);
    i_sym_valid = 0;
    drain("symbols");
    stall_sym = 1;
    i_sym_valid = 1;
    repeat (30) begin
      @(posedge i_mclk);
      took = o_sym_ready;
      #1;
      if (took)
        sym_f = 19'($urandom);
    end
    `CHECK(o_sym_ready, 1'b0)
    i_sym_valid = 0;
    stall_sym = 0;
    drain("sym_fill");
    summarize();
  end
endmodule

bind srio_tx_front srio_tx_front_assertions chk_u (.i_mclk, .i_rst,
  .i_tx_valid, .i_tx_discard, .o_tx_ready, .o_tx_next_ackid, .o_tx_rel_valid,
  .o_tx_rel_ackid, .i_acc_valid, .i_acc_ackid, .i_retry, .o_pkt_valid,
  .o_pkt_data, .o_pkt_sop, .o_pkt_eop, .o_pkt_stomp, .i_pkt_ready,
  .o_symq_valid, .o_symq_pair, .i_symq_ready);

/* File: verilog/ack_queue.v */
`timescale 1ns/10ps
`include "srio_tx_defines.vh"
// ----------------------------------------
// outstanding packet tracker
// ----------------------------------------
module ack_queue (
  input  wire       i_mclk,
  input  wire       i_rst,
  input  wire       i_commit,
  input  wire       i_acc_valid,
  input  wire [4:0] i_acc_ackid,
  input  wire       i_retry,
  output reg  [4:0] o_next_ackid,
  output reg        o_rel_valid,
  output reg  [4:0] o_rel_ackid,
  output reg        o_full
);
  reg  [4:0] oldest_q;
  reg  [5:0] cnt_q;
  reg  [5:0] cnt_d;
  wire       rel;

  // acceptance is in order, so only the oldest id can be released
  assign rel = i_acc_valid & (i_acc_ackid == oldest_q) & (cnt_q != 6'h00);

  always @* begin
    cnt_d = cnt_q;
    if (i_retry) begin
      cnt_d = 6'h00;
    end else if (i_commit & ~rel) begin
      cnt_d = cnt_q + 6'h01;
    end else if (rel & ~i_commit) begin
      cnt_d = cnt_q - 6'h01;
    end
  end

  // retry rewinds the next id to the oldest unacknowledged one
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_next_ackid <= 5'h00;
      oldest_q     <= 5'h00;
      cnt_q        <= 6'h00;
      o_rel_valid  <= 1'b0;
      o_rel_ackid  <= 5'h00;
      o_full       <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      o_full      <= (cnt_d == `ACKQ_DEPTH);
      o_rel_valid <= rel & ~i_retry;
      if (rel & ~i_retry) begin
        o_rel_ackid <= oldest_q;
        oldest_q    <= oldest_q + `ACK_ONE;
      end
      if (i_retry) begin
        o_next_ackid <= rel ? oldest_q + `ACK_ONE : oldest_q;
      end else if (i_commit) begin
        o_next_ackid <= o_next_ackid + `ACK_ONE;
      end
    end
  end
endmodule

/* File: verilog/srio_tx_defines.vh */
`ifndef SRIO_TX_DEFINES_VH
`define SRIO_TX_DEFINES_VH

// ----------------------------------------
// packet crc
// ----------------------------------------
`define CRC16_POLY   16'h1021
`define CRC16_INIT   16'hffff
`define HDR_KEEP     16'h03ff
`define MID_CRC_HW   9'h028
`define HW_ONE       9'h001

// ----------------------------------------
// control symbols
// ----------------------------------------
`define CRC5_POLY    5'h15
`define CRC5_INIT    5'h1f
`define SC_CHAR      8'h1c
`define STYPE0_STAT  3'h4
`define STYPE1_NOP   3'h7
`define STAT_BUFS    5'h1f
`define CMD_NONE     3'h0
`define PAR_NONE     5'h00

// ----------------------------------------
// queues and acknowledge ids
// ----------------------------------------
`define DFIFO_W      35
`define DFIFO_DEPTH  32
`define DFIFO_AW     5
`define SFIFO_W      64
`define SFIFO_DEPTH  8
`define SFIFO_AW     3
`define SFIFO_ROOM   4'h6
`define ACKQ_DEPTH   6'h20
`define ACK_ONE      5'h01

`endif

/* File: verilog/srio_tx_front.v */
`timescale 1ns/10ps
`include "srio_tx_defines.vh"
// Notes on behaviour
// - ready high whenever a word can be taken
// - discard drops the packet in progress
// - next ack id names packet to send
// - released ack id frees user buffer slot
// - ack id chosen by outstanding queue
// - data goes crc stage then assembly fifo
// - crc16 poly 1021 over header, payload
// - crc preset to all ones per packet
// - ack id and reserved bit fed zero
// - short packets get one trailing crc
// - long packets get crc after 80 bytes
// - running crc continues through inserted crc
// - zero halfword pads to 32-bit boundary
// - symbols built on request, queued
// - symbol is delimiter plus 24 bits
// - each queue entry holds two symbols
// - lone symbol paired with status/nop filler
// - status stype0 code is binary 100
// - symbol carries 5-bit crc
module srio_tx_front (
  input  wire        i_mclk,
  input  wire        i_rst,
  input  wire        i_tx_valid,
  input  wire        i_tx_sop,
  input  wire        i_tx_eop,
  input  wire        i_tx_half,
  input  wire [31:0] i_tx_data,
  input  wire        i_tx_discard,
  output reg         o_tx_ready,
  output wire [4:0]  o_tx_next_ackid,
  output wire        o_tx_rel_valid,
  output wire [4:0]  o_tx_rel_ackid,
  input  wire        i_acc_valid,
  input  wire [4:0]  i_acc_ackid,
  input  wire        i_retry,
  output wire        o_pkt_valid,
  output wire [31:0] o_pkt_data,
  output wire        o_pkt_sop,
  output wire        o_pkt_eop,
  output wire        o_pkt_stomp,
  input  wire        i_pkt_ready,
  input  wire        i_sym_valid,
  input  wire [2:0]  i_sym_stype0,
  input  wire [4:0]  i_sym_par0,
  input  wire [4:0]  i_sym_par1,
  input  wire [2:0]  i_sym_stype1,
  input  wire [2:0]  i_sym_cmd,
  output reg         o_sym_ready,
  output wire        o_symq_valid,
  output wire [63:0] o_symq_pair,
  input  wire        i_symq_ready
);
  localparam ST_WAIT = 3'b000;
  localparam ST_UP   = 3'b001;
  localparam ST_LO   = 3'b010;
  localparam ST_CRC  = 3'b011;
  localparam ST_PAD  = 3'b100;

  // ----------------------------------------
  // crc helpers
  // ----------------------------------------
  // one halfword through the packet crc, msb first
  function [15:0] crc16_hw;
    input [15:0] c;
    input [15:0] d;
    integer i;
    reg [15:0] r;
    begin
      r = c;
      for (i = 15; i >= 0; i = i - 1) begin
        if (r[15] ^ d[i]) begin
          r = {r[14:0], 1'b0} ^ `CRC16_POLY;
        end else begin
          r = {r[14:0], 1'b0};
        end
      end
      crc16_hw = r;
    end
  endfunction

  // full symbol word: delimiter, 19 body bits, crc5
  function [31:0] mk_sym;
    input [18:0] b;
    integer i;
    reg [4:0] r;
    begin
      r = `CRC5_INIT;
      for (i = 18; i >= 0; i = i - 1) begin
        if (r[4] ^ b[i]) begin
          r = {r[3:0], 1'b0} ^ `CRC5_POLY;
        end else begin
          r = {r[3:0], 1'b0};
        end
      end
      mk_sym = {`SC_CHAR, b, r};
    end
  endfunction

  // ----------------------------------------
  // packet engine state
  // ----------------------------------------
  reg  [2:0]  st_q;
  reg  [31:0] word_q;
  reg         eop_q;
  reg         half_q;
  reg         first_q;
  reg         inpkt_q;
  reg         disc_q;
  reg         mid_q;
  reg  [8:0]  hw_cnt_q;
  reg  [15:0] crc_q;
  reg         pk_have_q;
  reg         pk_sop_q;
  reg  [15:0] pk_hi_q;
  reg         emit_v;
  reg  [15:0] emit_hw;
  reg         emit_end;
  reg         disc_push;
  wire        dfifo_rdy;
  wire        dfifo_push;
  wire [34:0] dfifo_data;
  wire        acq_full;
  wire        take;
  wire        is_last;
  wire [15:0] cur_hw;
  wire [15:0] hw_crc;
  wire [15:0] hw_out;
  wire [8:0]  cnt_inc;
  wire        commit;
  wire        wait_next;

  assign take    = o_tx_ready & i_tx_valid & ~i_tx_discard &
                   (inpkt_q | i_tx_sop);
  assign cur_hw  = (st_q == ST_LO) ? word_q[15:0] : word_q[31:16];
  assign is_last = eop_q & ((st_q == ST_LO) | half_q);
  // crc sees zeros in the id field, output carries the live id
  assign hw_crc  = first_q ? (cur_hw & `HDR_KEEP) : cur_hw;
  assign hw_out  = first_q ? {o_tx_next_ackid, 1'b0, cur_hw[9:0]}
                           : cur_hw;
  assign cnt_inc = hw_cnt_q + `HW_ONE;
  assign commit  = emit_v & (st_q == ST_CRC) & ~mid_q;

  // ----------------------------------------
  // halfword emission
  // ----------------------------------------
  // a pending discard beats data; nothing moves while the fifo is full
  always @* begin
    emit_v    = 1'b0;
    emit_hw   = hw_out;
    emit_end  = 1'b0;
    disc_push = 1'b0;
    if (dfifo_rdy) begin
      if (disc_q) begin
        disc_push = 1'b1;
      end else begin
        case (st_q)
          ST_UP, ST_LO: begin
            emit_v = 1'b1;
          end
          ST_CRC: begin
            emit_v   = 1'b1;
            emit_hw  = crc_q;
            emit_end = ~mid_q & pk_have_q;
          end
          ST_PAD: begin
            emit_v   = 1'b1;
            emit_hw  = 16'h0000;
            emit_end = 1'b1;
          end
          default: begin
            emit_v = 1'b0;
          end
        endcase
      end
    end
  end

  // words form from halfword pairs; a stomp entry closes a dropped packet
  assign dfifo_push = disc_push | (emit_v & pk_have_q);
  assign dfifo_data = disc_push ? {3'b011, 32'h0000_0000}
                    : {pk_sop_q, emit_end, 1'b0, pk_hi_q, emit_hw};

  // engine comes back to waiting for a user word
  assign wait_next = disc_push
    | ((st_q == ST_WAIT) & ~take)
    | ((st_q == ST_LO) & emit_v & ~is_last & (cnt_inc != `MID_CRC_HW))
    | ((st_q == ST_CRC) & emit_v & (mid_q | pk_have_q))
    | ((st_q == ST_PAD) & emit_v);

  // ----------------------------------------
  // packet engine
  // ----------------------------------------
  always @(posedge i_mclk) begin
    if (i_rst) begin
      st_q       <= ST_WAIT;
      word_q     <= 32'h0000_0000;
      eop_q      <= 1'b0;
      half_q     <= 1'b0;
      first_q    <= 1'b0;
      inpkt_q    <= 1'b0;
      disc_q     <= 1'b0;
      mid_q      <= 1'b0;
      hw_cnt_q   <= 9'h000;
      crc_q      <= `CRC16_INIT;
      pk_have_q  <= 1'b0;
      pk_sop_q   <= 1'b0;
      pk_hi_q    <= 16'h0000;
      o_tx_ready <= 1'b0;
    end else begin
      // ready only when the next cycle can take a word
      o_tx_ready <= wait_next & ~acq_full & ~disc_q &
                    ~(i_tx_discard & inpkt_q);
      // discard is held until the stomp entry fits in the fifo
      if (disc_push) begin
        disc_q <= 1'b0;
      end else if (i_tx_discard & inpkt_q) begin
        disc_q <= 1'b1;
      end
      // halfword packer
      if (disc_push) begin
        pk_have_q <= 1'b0;
        pk_sop_q  <= 1'b0;
      end else if (emit_v) begin
        if (pk_have_q) begin
          pk_have_q <= 1'b0;
          pk_sop_q  <= 1'b0;
        end else begin
          pk_hi_q   <= emit_hw;
          pk_have_q <= 1'b1;
        end
      end
      if (disc_push) begin
        st_q    <= ST_WAIT;
        inpkt_q <= 1'b0;
      end else begin
        case (st_q)
          ST_WAIT: begin
            if (take) begin
              word_q <= i_tx_data;
              eop_q  <= i_tx_eop;
              half_q <= i_tx_half;
              st_q   <= ST_UP;
              if (~inpkt_q) begin
                inpkt_q  <= 1'b1;
                first_q  <= 1'b1;
                crc_q    <= `CRC16_INIT;
                hw_cnt_q <= 9'h000;
                pk_sop_q <= 1'b1;
              end
            end
          end
          ST_UP, ST_LO: begin
            if (emit_v) begin
              crc_q    <= crc16_hw(crc_q, hw_crc);
              first_q  <= 1'b0;
              hw_cnt_q <= cnt_inc;
              mid_q    <= ~is_last;
              if (is_last) begin
                st_q <= ST_CRC;
              end else if (st_q == ST_UP) begin
                st_q <= ST_LO;
              end else if (cnt_inc == `MID_CRC_HW) begin
                st_q <= ST_CRC;
              end else begin
                st_q <= ST_WAIT;
              end
            end
          end
          ST_CRC: begin
            if (emit_v) begin
              // inserted value feeds the running crc, no re-preset
              crc_q <= crc16_hw(crc_q, crc_q);
              if (mid_q) begin
                st_q <= ST_WAIT;
              end else if (pk_have_q) begin
                st_q    <= ST_WAIT;
                inpkt_q <= 1'b0;
              end else begin
                st_q <= ST_PAD;
              end
            end
          end
          ST_PAD: begin
            if (emit_v) begin
              st_q    <= ST_WAIT;
              inpkt_q <= 1'b0;
            end
          end
          default: begin
            st_q <= ST_WAIT;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // data fifo and acknowledge ids
  // ----------------------------------------
  sync_fifo #(
    .W  (`DFIFO_W),
    .D  (`DFIFO_DEPTH),
    .AW (`DFIFO_AW)
  ) u_dfifo (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_valid (dfifo_push),
    .o_ready (dfifo_rdy),
    .i_data  (dfifo_data),
    .o_valid (o_pkt_valid),
    .o_data  ({o_pkt_sop, o_pkt_eop, o_pkt_stomp, o_pkt_data}),
    .i_ready (i_pkt_ready),
    .o_level ()
  );

  // id advances only when a packet completes, not on discard
  ack_queue u_ackq (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_commit     (commit),
    .i_acc_valid  (i_acc_valid),
    .i_acc_ackid  (i_acc_ackid),
    .i_retry      (i_retry),
    .o_next_ackid (o_tx_next_ackid),
    .o_rel_valid  (o_tx_rel_valid),
    .o_rel_ackid  (o_tx_rel_ackid),
    .o_full       (acq_full)
  );

  // ----------------------------------------
  // symbol generator
  // ----------------------------------------
  reg         hold_q;
  reg  [31:0] hold_sym_q;
  wire        sym_acc;
  wire [31:0] new_sym;
  wire [31:0] fill_sym;
  wire        sfifo_rdy;
  wire [3:0]  sfifo_lvl;
  wire        sym_push;

  assign sym_acc  = o_sym_ready & i_sym_valid;
  assign new_sym  = mk_sym({i_sym_stype0, i_sym_par0, i_sym_par1,
                            i_sym_stype1, i_sym_cmd});
  assign fill_sym = mk_sym({`STYPE0_STAT, `PAR_NONE, `STAT_BUFS,
                            `STYPE1_NOP, `CMD_NONE});
  // a lone symbol goes out a cycle later with the filler beside it
  assign sym_push = hold_q & (sym_acc | sfifo_rdy);

  // hold the first symbol of a pair
  always @(posedge i_mclk) begin
    if (i_rst) begin
      hold_q      <= 1'b0;
      hold_sym_q  <= 32'h0000_0000;
      o_sym_ready <= 1'b0;
    end else begin
      // margin of one because ready lags the level by a cycle
      o_sym_ready <= (sfifo_lvl <= `SFIFO_ROOM);
      if (sym_acc & ~hold_q) begin
        hold_q     <= 1'b1;
        hold_sym_q <= new_sym;
      end else if (sym_push) begin
        hold_q <= 1'b0;
      end
    end
  end

  sync_fifo #(
    .W  (`SFIFO_W),
    .D  (`SFIFO_DEPTH),
    .AW (`SFIFO_AW)
  ) u_sfifo (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_valid (sym_push),
    .o_ready (sfifo_rdy),
    .i_data  ({hold_sym_q, sym_acc ? new_sym : fill_sym}),
    .o_valid (o_symq_valid),
    .o_data  (o_symq_pair),
    .i_ready (i_symq_ready),
    .o_level (sfifo_lvl)
  );
endmodule

/* File: verilog/sync_fifo.v */
`timescale 1ns/10ps
// ----------------------------------------
// synchronous fifo, registered read side
// ----------------------------------------
module sync_fifo #(
  parameter W  = 35,
  parameter D  = 32,
  parameter AW = 5
) (
  input  wire          i_mclk,
  input  wire          i_rst,
  input  wire          i_valid,
  output wire          o_ready,
  input  wire [W-1:0]  i_data,
  output reg           o_valid,
  output reg  [W-1:0]  o_data,
  input  wire          i_ready,
  output wire [AW:0]   o_level
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         load;

  // full and empty come straight from the stored count
  assign o_ready = (cnt_q < D[AW:0]);
  assign o_level = cnt_q;
  assign push    = i_valid & o_ready;
  assign load    = (cnt_q != {(AW+1){1'b0}}) & (~o_valid | i_ready);

  // storage array has no reset; pointers, count and output stage do
  always @(posedge i_mclk) begin
    if (push) begin
      mem[wr_q] <= i_data;
    end
  end

  // pointers, count and output stage
  always @(posedge i_mclk) begin
    if (i_rst) begin
      wr_q    <= {AW{1'b0}};
      rd_q    <= {AW{1'b0}};
      cnt_q   <= {(AW+1){1'b0}};
      o_valid <= 1'b0;
      o_data  <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (load) begin
        rd_q    <= rd_q + {{(AW-1){1'b0}}, 1'b1};
        o_data  <= mem[rd_q];
        o_valid <= 1'b1;
      end else if (i_ready) begin
        o_valid <= 1'b0;
      end
      if (push & ~load) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (load & ~push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
